// file: hw/rsc_regs.vh
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// Register byte offsets
`define RSC_OFF_RCTL        8'h00
`define RSC_OFF_PCTL        8'h04
`define RSC_OFF_PLO         8'h08
`define RSC_OFF_PHI         8'h0c
`define RSC_OFF_STAT        8'h10

// Cause flag positions in the reset control register
`define RSC_BIT_TRAP        15
`define RSC_BIT_ILL         14
`define RSC_BIT_EXT         7
`define RSC_BIT_SW          6
`define RSC_BIT_WDT         4

// Field positions
`define RSC_BIT_PROT_EN     0
`define RSC_BIT_ST_RST      0
`define RSC_BIT_ST_LP       1
`define RSC_ST_INIT_LSB     16
`define RSC_PC_W            24

// Reset values
`define RSC_RST_RCTL        16'h0000
`define RSC_RST_PCTL        1'b0
`define RSC_RST_PADDR       24'h000000
`define RSC_RST_INIT        16'h8000

// Decode constants
`define RSC_ILLEGAL_OPCODE  8'h3f
`define RSC_SP_IDX          4'hf
`define RSC_LVL_HARD_MIN    4'hd
`define RSC_LVL_HARD_MAX    4'hf
`define RSC_LVL_ADDR_ERR    4'hd
`define RSC_LVL_OSC_FAIL    4'he

// Bus responses
`define RSC_RESP_OKAY       2'b00
`define RSC_RESP_SLVERR     2'b10

// Timing
`define RSC_CLK_PERIOD_NS   20
`define RSC_MIN_PULSE_NS    200
`define RSC_MIN_PULSE_CYC   ((`RSC_MIN_PULSE_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

`endif

// file: hw/rsc_reset_source_controller.v
// Overview of operation
// - Filtered low on reset pin longer than minimum width causes external reset.
// - External pin reset sets the external reset cause flag.
// - Reset instruction asserts system reset without clock re-initialization.
// - Software reset releases next cycle, then vector fetch begins.
// - Software reset sets cause flag bit 6.
// - Watchdog time-out outside low power resets, clock source untouched.
// - Watchdog time-out in sleep or idle only wakes the processor.
// - Watchdog reset sets cause flag bit 4.
// - Lower hard trap during higher trap service causes trap conflict reset.
// - Address error is level 13, oscillator failure level 14 hard trap.
// - Trap conflict reset sets cause flag bit 15.
// - Illegal opcode, uninitialized pointer or security fault set bit 14.
// - Executing an illegal opcode from program memory resets the device.
// - Upper instruction byte 3Fh decodes as illegal opcode.
// - Uninitialized working register used as pointer resets the device.
// - Resets clear working registers except stack pointer; marked uninitialized.
// - Flow change into restricted protected segment causes security reset.
// - Program flow change is any branch reloading the program counter.
// - Vector flow change is program counter loaded with a vector.
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_reset_source_controller (
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output wire [1:0]  s_axi_bresp_out,
  output wire        s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0]  s_axi_rresp_out,
  output wire        s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        master_clear_pin_in,
  input  wire        reset_instr_in,
  input  wire        watchdog_timeout_in,
  input  wire        low_power_in,
  input  wire        trap_req_in,
  input  wire [3:0]  trap_level_in,
  input  wire        address_error_trap_in,
  input  wire        osc_fail_trap_in,
  input  wire        trap_active_in,
  input  wire [3:0]  trap_active_level_in,
  input  wire        fetch_valid_in,
  input  wire [7:0]  fetch_upper_in,
  input  wire        wreg_write_in,
  input  wire [3:0]  wreg_write_idx_in,
  input  wire        ptr_use_in,
  input  wire [3:0]  ptr_idx_in,
  input  wire        pc_load_in,
  input  wire        pc_load_vector_in,
  input  wire [23:0] pc_target_in,
  output wire        system_reset_signal_out,
  output wire        clock_reinit_out,
  output wire        vector_fetch_out,
  output wire        wreg_clear_out,
  output wire        wake_out
);

  localparam integer MIN_CYC_I = `RSC_MIN_PULSE_CYC;
  localparam [7:0]   MIN_CYC   = MIN_CYC_I[7:0];

  reg  [2:0]  pin_sync_reg;
  reg  [7:0]  low_cnt_reg;
  reg         ext_hold_reg;
  reg         system_reset_signal_reg;
  reg         clock_reinit_reg;
  reg         vector_fetch_reg;
  reg         wreg_clear_reg;
  reg         wake_reg;
  reg  [15:0] wreg_init_reg;
  reg  [15:0] rctl_reg;
  reg         prot_en_reg;
  reg  [23:0] prot_lo_reg;
  reg  [23:0] prot_hi_reg;
  reg         aw_have_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_have_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         awready_reg;
  reg         wready_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         arready_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;

  reg         aw_have_next;
  reg         w_have_next;
  reg         bvalid_next;
  reg  [15:0] rctl_next;
  reg  [3:0]  req_lvl;
  reg         req_hard;
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;

  wire        pin_agree;
  wire        pin_level;
  wire        ext_hold;
  wire        ext_start;
  wire        sw_evt;
  wire        wdt_evt;
  wire        wake_evt;
  wire        trap_evt;
  wire        illop_evt;
  wire        uninit_evt;
  wire        prog_flow_chg;
  wire        vec_flow_chg;
  wire        flow_chg;
  wire        sec_evt;
  wire        ill_evt;
  wire        pulse_evt;
  wire        aw_take;
  wire        w_take;
  wire        do_write;
  wire        ar_take;
  wire [31:0] wmask;
  wire        rctl_sel;
  wire        wr_ok;
  wire [15:0] rctl_clr;

  assign s_axi_awready_out       = awready_reg;
  assign s_axi_wready_out        = wready_reg;
  assign s_axi_bvalid_out        = bvalid_reg;
  assign s_axi_bresp_out         = bresp_reg;
  assign s_axi_arready_out       = arready_reg;
  assign s_axi_rvalid_out        = rvalid_reg;
  assign s_axi_rdata_out         = rdata_reg;
  assign s_axi_rresp_out         = rresp_reg;
  assign system_reset_signal_out = system_reset_signal_reg;
  assign clock_reinit_out        = clock_reinit_reg;
  assign vector_fetch_out        = vector_fetch_reg;
  assign wreg_clear_out          = wreg_clear_reg;
  assign wake_out                = wake_reg;

  // Reset pin synchroniser and glitch filter
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync_reg <= 3'h7;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], master_clear_pin_in};
    end
  end

  assign pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
  assign pin_level = pin_sync_reg[2];

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_cnt_reg  <= 8'h00;
      ext_hold_reg <= 1'b0;
    end else begin
      ext_hold_reg <= ext_hold;
      if (pin_agree && !pin_level) begin
        if (low_cnt_reg < MIN_CYC)
          low_cnt_reg <= low_cnt_reg + 8'h01;
      end else if (pin_agree) begin
        low_cnt_reg <= 8'h00;
      end
    end
  end

  assign ext_hold  = low_cnt_reg == MIN_CYC;
  assign ext_start = ext_hold && !ext_hold_reg;

  // Reset sources
  assign sw_evt   = reset_instr_in;
  assign wdt_evt  = watchdog_timeout_in && !low_power_in;
  assign wake_evt = watchdog_timeout_in && low_power_in;

  // Incoming hard trap level
  always @* begin
    req_lvl  = 4'h0;
    req_hard = 1'b0;
    if (trap_req_in && trap_level_in >= `RSC_LVL_HARD_MIN &&
        trap_level_in <= `RSC_LVL_HARD_MAX) begin
      req_lvl  = trap_level_in;
      req_hard = 1'b1;
    end else if (osc_fail_trap_in) begin
      req_lvl  = `RSC_LVL_OSC_FAIL;
      req_hard = 1'b1;
    end else if (address_error_trap_in) begin
      req_lvl  = `RSC_LVL_ADDR_ERR;
      req_hard = 1'b1;
    end
  end

  assign trap_evt = req_hard && trap_active_in &&
                    (trap_active_level_in > req_lvl);

  assign illop_evt  = fetch_valid_in &&
                      (fetch_upper_in == `RSC_ILLEGAL_OPCODE);
  assign uninit_evt = ptr_use_in && !wreg_init_reg[ptr_idx_in];
  assign prog_flow_chg = pc_load_in && !pc_load_vector_in;
  assign vec_flow_chg  = pc_load_in && pc_load_vector_in;
  assign flow_chg      = prog_flow_chg || vec_flow_chg;
  assign sec_evt    = flow_chg && prot_en_reg &&
                      (pc_target_in >= prot_lo_reg) &&
                      (pc_target_in <= prot_hi_reg);
  assign ill_evt    = illop_evt || uninit_evt || sec_evt;

  assign pulse_evt = sw_evt || wdt_evt || trap_evt || ill_evt || ext_start;

  // System reset and companion strobes
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      system_reset_signal_reg       <= 1'b0;
      clock_reinit_reg <= 1'b0;
      vector_fetch_reg <= 1'b0;
      wreg_clear_reg   <= 1'b0;
      wake_reg         <= 1'b0;
    end else begin
      system_reset_signal_reg       <= pulse_evt || ext_hold;
      clock_reinit_reg <= ext_start;
      vector_fetch_reg <= system_reset_signal_reg && !(pulse_evt || ext_hold);
      wreg_clear_reg   <= pulse_evt;
      wake_reg         <= wake_evt;
    end
  end

  // Working register initialised marks
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wreg_init_reg <= `RSC_RST_INIT;
    end else if (pulse_evt) begin
      wreg_init_reg <= `RSC_RST_INIT;
    end else if (wreg_write_in) begin
      wreg_init_reg[wreg_write_idx_in] <= 1'b1;
    end
  end

  // Bus write channel
  assign aw_take  = s_axi_awvalid_in && awready_reg;
  assign w_take   = s_axi_wvalid_in && wready_reg;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wmask    = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                     {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign rctl_sel = do_write && (aw_addr_reg == `RSC_OFF_RCTL);
  assign rctl_clr = rctl_sel ? (w_data_reg[15:0] & wmask[15:0]) : 16'h0000;
  assign wr_ok    = (aw_addr_reg == `RSC_OFF_RCTL) ||
                    (aw_addr_reg == `RSC_OFF_PCTL) ||
                    (aw_addr_reg == `RSC_OFF_PLO)  ||
                    (aw_addr_reg == `RSC_OFF_PHI)  ||
                    (aw_addr_reg == `RSC_OFF_STAT);

  always @* begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    bvalid_next  = bvalid_reg;
    if (aw_take)
      aw_have_next = 1'b1;
    if (w_take)
      w_have_next = 1'b1;
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
    end else if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RSC_RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      bvalid_reg  <= bvalid_next;
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg  <= !w_have_next && !bvalid_next;
      if (aw_take)
        aw_addr_reg <= {s_axi_awaddr_in[7:2], 2'b00};
      if (w_take) begin
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (do_write)
        bresp_reg <= wr_ok ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end
  end

  // Cause flags: hardware set wins over software clear
  always @* begin
    rctl_next = rctl_reg & ~rctl_clr;
    if (ext_start)
      rctl_next[`RSC_BIT_EXT] = 1'b1;
    if (sw_evt)
      rctl_next[`RSC_BIT_SW] = 1'b1;
    if (wdt_evt)
      rctl_next[`RSC_BIT_WDT] = 1'b1;
    if (trap_evt)
      rctl_next[`RSC_BIT_TRAP] = 1'b1;
    if (ill_evt)
      rctl_next[`RSC_BIT_ILL] = 1'b1;
  end

  // Software registers, untouched by system reset
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rctl_reg    <= `RSC_RST_RCTL;
      prot_en_reg <= `RSC_RST_PCTL;
      prot_lo_reg <= `RSC_RST_PADDR;
      prot_hi_reg <= `RSC_RST_PADDR;
    end else begin
      rctl_reg <= rctl_next & 16'hc0d0;
      if (do_write && aw_addr_reg == `RSC_OFF_PCTL && w_strb_reg[0])
        prot_en_reg <= w_data_reg[`RSC_BIT_PROT_EN];
      if (do_write && aw_addr_reg == `RSC_OFF_PLO)
        prot_lo_reg <= (prot_lo_reg & ~wmask[23:0]) |
                       (w_data_reg[23:0] & wmask[23:0]);
      if (do_write && aw_addr_reg == `RSC_OFF_PHI)
        prot_hi_reg <= (prot_hi_reg & ~wmask[23:0]) |
                       (w_data_reg[23:0] & wmask[23:0]);
    end
  end

  // Bus read channel
  assign ar_take = s_axi_arvalid_in && arready_reg;

  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `RSC_RESP_OKAY;
    case ({s_axi_araddr_in[7:2], 2'b00})
      `RSC_OFF_RCTL: rd_word = {16'h0000, rctl_reg};
      `RSC_OFF_PCTL: rd_word = {31'h00000000, prot_en_reg};
      `RSC_OFF_PLO:  rd_word = {8'h00, prot_lo_reg};
      `RSC_OFF_PHI:  rd_word = {8'h00, prot_hi_reg};
      `RSC_OFF_STAT: begin
        rd_word[`RSC_BIT_ST_RST] = system_reset_signal_reg;
        rd_word[`RSC_BIT_ST_LP]  = low_power_in;
        rd_word[31:16]           = wreg_init_reg;
      end
      default:       rd_resp = `RSC_RESP_SLVERR;
    endcase
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `RSC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_word;
        rresp_reg   <= rd_resp;
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

endmodule

// file: verif/rsc_ext_sup.sv
`timescale 1ns/100ps
module rsc_ext_sup (
  input  wire       clk_in,
  input  wire       go_in,
  input  wire [7:0] low_cyc_in,
  output wire       pin_out
);
  reg [7:0] cnt_reg = 8'h00;

  // Holds the pin low for the requested number of cycles
  always @(posedge clk_in)
    if (go_in)
      cnt_reg <= low_cyc_in;
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;

  // Pin always driven, high when idle
  assign pin_out = (cnt_reg == 8'h00);
endmodule

// file: verif/rsc_reset_source_controller_chk.sv
`timescale 1ns/100ps
`include "rsc_regs.vh"
module rsc_chk (
  input wire       sys_clk_in,
  input wire       rstn_in,
  input wire       master_clear_pin_in,
  input wire       reset_instr_in,
  input wire       watchdog_timeout_in,
  input wire       low_power_in,
  input wire       trap_req_in,
  input wire [3:0] trap_level_in,
  input wire       trap_active_in,
  input wire [3:0] trap_active_level_in,
  input wire       fetch_valid_in,
  input wire [7:0] fetch_upper_in,
  input wire       system_reset_signal_out,
  input wire       clock_reinit_out,
  input wire       vector_fetch_out,
  input wire       wreg_clear_out,
  input wire       wake_out
);
  reg [7:0] low_cnt;

  // Length of the current low run on the pin
  always @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      low_cnt <= 8'h00;
    else if (master_clear_pin_in)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  chk_sw_pulse: assert property (
    reset_instr_in && !system_reset_signal_out |=> system_reset_signal_out
    ##1 (!system_reset_signal_out && vector_fetch_out))
    else $error("software reset pulse wrong");
  chk_sw_noclk: assert property (
    reset_instr_in |=> !clock_reinit_out)
    else $error("clock reinit on software reset");
  chk_wdt_reset: assert property (
    watchdog_timeout_in && !low_power_in
    |=> system_reset_signal_out && !clock_reinit_out)
    else $error("watchdog reset wrong");
  chk_wdt_wake: assert property (
    watchdog_timeout_in && low_power_in && !system_reset_signal_out
    |=> wake_out && !system_reset_signal_out)
    else $error("watchdog wake wrong");
  chk_bad_opcode: assert property (
    fetch_valid_in && fetch_upper_in == `RSC_ILLEGAL_OPCODE
    |=> system_reset_signal_out)
    else $error("illegal opcode did not reset");
  chk_trap_hit: assert property (
    trap_req_in && trap_active_in && trap_level_in >= `RSC_LVL_HARD_MIN
    && trap_level_in < trap_active_level_in |=> system_reset_signal_out)
    else $error("trap conflict did not reset");
  chk_wreg_clear: assert property (
    $rose(system_reset_signal_out) |-> wreg_clear_out)
    else $error("working registers not cleared");
  chk_pin_width: assert property (
    clock_reinit_out |-> low_cnt >= `RSC_MIN_PULSE_CYC)
    else $error("pin reset on short pulse");

  cover property (wake_out);
  cover property ($rose(system_reset_signal_out) && clock_reinit_out);
  cover property ($fell(system_reset_signal_out) ##0 vector_fetch_out);
endmodule

bind rsc_reset_source_controller rsc_chk rsc_chk_inst (
  .sys_clk_in, .rstn_in, .master_clear_pin_in, .reset_instr_in,
  .watchdog_timeout_in, .low_power_in, .trap_req_in, .trap_level_in,
  .trap_active_in, .trap_active_level_in, .fetch_valid_in,
  .fetch_upper_in, .system_reset_signal_out, .clock_reinit_out,
  .vector_fetch_out, .wreg_clear_out, .wake_out);

// file: verif/tb_rsc_reset_source_controller.sv
`timescale 1ns/100ps
`include "rsc_regs.vh"
`define CK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  miscompares++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module tb_rsc_reset_source_controller;
  logic        clk = 0, rstn = 0, go = 0, lp = 0, act = 0, pcv = 0;
  logic        aw = 0, w = 0, br = 0, ar = 0, rr = 0;
  logic [8:0]  ev = 0;
  logic [7:0]  adr = 0, upr = 0, lcyc = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  tl = 0, al = 0, idx = 0;
  logic [23:0] tgt = 0;
  logic [1:0]  resp;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pin, awr, wr, bv, arr, rv, rst, cri, vf, wclr, wake;
  integer      miscompares = 0, tests_run = 0, n;

  always #10 clk = ~clk;

  rsc_ext_sup rsc_ext_sup_inst (.clk_in(clk), .go_in(go),
    .low_cyc_in(lcyc), .pin_out(pin));

  rsc_reset_source_controller rsc_reset_source_controller_inst (
    .sys_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(adr),
    .s_axi_awvalid_in(aw), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(adr), .s_axi_arvalid_in(ar), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .master_clear_pin_in(pin), .reset_instr_in(ev[0]),
    .watchdog_timeout_in(ev[1]), .low_power_in(lp), .trap_req_in(ev[2]),
    .trap_level_in(tl), .address_error_trap_in(ev[3]),
    .osc_fail_trap_in(ev[4]), .trap_active_in(act),
    .trap_active_level_in(al), .fetch_valid_in(ev[5]),
    .fetch_upper_in(upr), .wreg_write_in(ev[6]), .wreg_write_idx_in(idx),
    .ptr_use_in(ev[7]), .ptr_idx_in(idx), .pc_load_in(ev[8]),
    .pc_load_vector_in(pcv), .pc_target_in(tgt),
    .system_reset_signal_out(rst), .clock_reinit_out(cri),
    .vector_fetch_out(vf), .wreg_clear_out(wclr), .wake_out(wake));

  task automatic wr_reg(input [7:0] a, input [31:0] d, input [1:0] e);
    adr <= a; wd <= d; aw <= 1; w <= 1; br <= 1;
    do begin
      @(posedge clk);
      if (awr) aw <= 0;
      if (wr) w <= 0;
    end while (!bv);
    br <= 0;
    `CK(bresp, e)
    @(posedge clk);
  endtask

  task automatic rd_reg(input [7:0] a);
    adr <= a; ar <= 1; rr <= 1;
    do begin
      @(posedge clk);
      if (arr) ar <= 0;
    end while (!rv);
    rr <= 0; rd = rdata; resp = rresp;
    @(posedge clk);
  endtask

  // Fires core events, checks reset pulse and cause flags, then clears
  task automatic evt(input [8:0] e, input r, input [15:0] f);
    ev <= e;
    @(posedge clk);
    ev <= 0;
    #1 `CK({rst, wclr, cri}, {r, r, 1'b0})
    @(posedge clk);
    #1 `CK({rst, vf}, {1'b0, r})
    @(posedge clk);
    rd_reg(`RSC_OFF_RCTL);
    `CK(rd[15:0], f)
    wr_reg(`RSC_OFF_RCTL, 32'hffff, `RSC_RESP_OKAY);
  endtask

  task s_bus;
    rd_reg(`RSC_OFF_RCTL);
    `CK(rd, 32'h0)
    rd_reg(8'h20);
    `CK({resp, rd}, {`RSC_RESP_SLVERR, 32'h0})
    wr_reg(8'h20, 32'h1, `RSC_RESP_SLVERR);
    lp <= 1;
    rd_reg(`RSC_OFF_STAT);
    `CK(rd, {`RSC_RST_INIT, 16'h0002})
    lp <= 0;
    $display("bus test done");
  endtask

  task s_sw;
    evt(9'h001, 1, 16'h1 << `RSC_BIT_SW);
    $display("software reset test done");
  endtask

  task s_wdt;
    evt(9'h002, 1, 16'h1 << `RSC_BIT_WDT);
    lp <= 1; ev <= 9'h002;
    @(posedge clk);
    ev <= 0;
    #1 `CK({rst, wake}, 2'b01)
    @(posedge clk);
    lp <= 0;
    rd_reg(`RSC_OFF_RCTL);
    `CK(rd[15:0], 16'h0)
    $display("watchdog test done");
  endtask

  task s_trap;
    act <= 1; al <= 4'hf; tl <= 4'hd;
    evt(9'h004, 1, 16'h1 << `RSC_BIT_TRAP);
    al <= 4'he;
    evt(9'h008, 1, 16'h1 << `RSC_BIT_TRAP);
    al <= 4'hf;
    evt(9'h010, 1, 16'h1 << `RSC_BIT_TRAP);
    al <= 4'hd;
    evt(9'h010, 0, 16'h0);
    al <= 4'hf; tl <= 4'hc;
    evt(9'h004, 0, 16'h0);
    act <= 0;
    $display("trap test done");
  endtask

  task s_ill;
    upr <= 8'h3f;
    evt(9'h020, 1, 16'h1 << `RSC_BIT_ILL);
    upr <= 8'h3e;
    evt(9'h020, 0, 16'h0);
    idx <= 4'h3;
    evt(9'h080, 1, 16'h1 << `RSC_BIT_ILL);
    evt(9'h040, 0, 16'h0);
    evt(9'h080, 0, 16'h0);
    idx <= 4'hf;
    evt(9'h080, 0, 16'h0);
    evt(9'h001, 1, 16'h1 << `RSC_BIT_SW);
    idx <= 4'h3;
    evt(9'h080, 1, 16'h1 << `RSC_BIT_ILL);
    $display("illegal condition test done");
  endtask

  task s_sec;
    wr_reg(`RSC_OFF_PLO, 32'h100, `RSC_RESP_OKAY);
    wr_reg(`RSC_OFF_PHI, 32'h1ff, `RSC_RESP_OKAY);
    wr_reg(`RSC_OFF_PCTL, 32'h1, `RSC_RESP_OKAY);
    tgt <= 24'h000180;
    evt(9'h100, 1, 16'h1 << `RSC_BIT_ILL);
    pcv <= 1; tgt <= 24'h000100;
    evt(9'h100, 1, 16'h1 << `RSC_BIT_ILL);
    tgt <= 24'h000200;
    evt(9'h100, 0, 16'h0);
    pcv <= 0;
    $display("security test done");
  endtask

  task s_pin;
    lcyc <= 8'h05; go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (30) begin
      @(posedge clk);
      #1 `CK(rst, 1'b0)
    end
    lcyc <= 8'h28; go <= 1;
    @(posedge clk);
    go <= 0;
    n = 0;
    while (!rst && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    `CK({rst, cri}, 2'b11)
    repeat (60) @(posedge clk);
    `CK({rst, pin}, 2'b01)
    rd_reg(`RSC_OFF_RCTL);
    `CK(rd[15:0], 16'h1 << `RSC_BIT_EXT)
    $display("pin reset test done");
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    s_bus;
    s_sw;
    s_wdt;
    s_trap;
    s_ill;
    s_sec;
    s_pin;
    close_out;
  end

  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule
